// >>> src/acec_regs.svh
`ifndef ACEC_REGS_SVH
`define ACEC_REGS_SVH

// Register offsets on the plain register port
`define ACEC_OFS_CTRL1     4'h0
`define ACEC_OFS_CTRL2     4'h1
`define ACEC_OFS_CTRL3     4'h2
`define ACEC_OFS_STATUS    4'h3
`define ACEC_OFS_IRQ_STAT  4'h4
`define ACEC_OFS_IRQ_MASK  4'h5

// Control register field positions
`define ACEC_BIT_EN        7
`define ACEC_BIT_IE        6
`define ACEC_SENSE_MSB     5
`define ACEC_SENSE_LSB     4
`define ACEC_BIT_ROUTE     3
`define ACEC_NEG_MSB       2
`define ACEC_NEG_LSB       0

// Status register field positions
`define ACEC_FLAG_LSB      4
`define ACEC_LEVEL_LSB     0

// Sensitivity codes
`define ACEC_SENSE_TOGGLE  2'h0
`define ACEC_SENSE_RSVD    2'h1
`define ACEC_SENSE_FALL    2'h2
`define ACEC_SENSE_RISE    2'h3

// Negative input select code with no source behind it
`define ACEC_NEG_RSVD      3'h7

// Reset values
`define ACEC_CTRL_RST      8'h00
`define ACEC_STATUS_RST    8'h00
`define ACEC_MASK_RST      4'h0

`endif

// >>> src/acec_pkg.sv
package acec_pkg;

  // Whole state of the comparator event controller
  typedef struct packed {
    logic [3:1][7:0] ctrl;      // Control registers of comparators 1 to 3
    logic [3:0]      flag;      // Event flags, comparators 3 to 0
    logic [3:0]      level;     // Sampled comparator outputs
    logic [3:0]      irq_stat;  // Sticky interrupt status, clear on read
    logic [3:0]      irq_mask;  // Interrupt mask
    logic [3:0]      cmp_irq;   // Per-comparator interrupt requests
    logic            irq;       // Summary interrupt
    logic [7:0]      rdata;     // Read data, valid one cycle after a read
    logic            cap_level; // Comparator 1 level toward capture front end
    logic            cap_event; // Capture edge seen on comparator 1
  } acec_state_type;

endpackage

// >>> src/acec_ctrl.sv
`timescale 1ns/100ps
`include "acec_regs.svh"

module acec_ctrl
  import acec_pkg::*;
(
  // Clock and reset
  input  logic             sys_clk,
  input  logic             reset,
  // Register port
  input  logic [3:0]       reg_addr,
  input  logic [7:0]       reg_wdata,
  input  logic             reg_wr,
  input  logic             reg_rd,
  output logic [7:0]       reg_rdata,
  // Analog comparator side
  input  logic [3:1]       cmp_out_raw,
  output logic [3:1]       cmp_enable,
  output logic [3:1][2:0]  cmp_neg_sel,
  output logic [3:1]       cmp_neg_valid,
  // Comparator 0, controlled elsewhere
  input  logic             cmp0_out,
  input  logic             cmp0_event,
  input  logic             cmp0_irq_en,
  // Processor interrupt logic
  input  logic [3:0]       vector_ack,
  output logic [3:0]       cmp_irq_req,
  output logic             irq,
  // ADC and DAC trigger sources
  output logic [3:0]       cmp_trigger,
  // Timer input capture
  input  logic             timer_capture_edge_sel,
  output logic             capture_src,
  output logic             capture_event
);

  acec_state_type s_reg;
  acec_state_type s_next;

  logic [3:0] evt;
  logic [3:0] ie;
  logic [3:0] w1c;
  logic [3:0] ack_clr;
  logic [7:0] rd_val;
  logic       route;

  // Event match for one comparator given its sensitivity code
  function automatic logic sense_hit(input logic [1:0] sense,
                                     input logic       prev,
                                     input logic       cur);
    logic hit;
    hit = 1'b0;
    case (sense)
      `ACEC_SENSE_TOGGLE: hit = prev ^ cur;
      `ACEC_SENSE_FALL:   hit = prev & ~cur;
      `ACEC_SENSE_RISE:   hit = ~prev & cur;
      default:            hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Read decode, reserved bits of controls 2 and 3 forced low
  function automatic logic [7:0] read_mux(input logic [3:0]     addr,
                                          input acec_state_type st);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `ACEC_OFS_CTRL1:    v = st.ctrl[1];
      `ACEC_OFS_CTRL2:    v = st.ctrl[2] & 8'hf7;
      `ACEC_OFS_CTRL3:    v = st.ctrl[3] & 8'hf7;
      `ACEC_OFS_STATUS:   v = {st.flag, st.level};
      `ACEC_OFS_IRQ_STAT: v = {4'h0, st.irq_stat};
      `ACEC_OFS_IRQ_MASK: v = {4'h0, st.irq_mask};
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // Next-state logic
  always_comb begin
    s_next  = s_reg;
    evt     = 4'h0;
    ie      = {s_reg.ctrl[3][`ACEC_BIT_IE], s_reg.ctrl[2][`ACEC_BIT_IE],
               s_reg.ctrl[1][`ACEC_BIT_IE], cmp0_irq_en};
    w1c     = 4'h0;
    ack_clr = vector_ack & ie;
    route   = s_reg.ctrl[1][`ACEC_BIT_ROUTE];
    rd_val  = read_mux(reg_addr, s_reg);

    // Events from the enabled comparators
    evt[0] = cmp0_event;
    for (int i = 1; i < 4; i++) begin
      evt[i] = s_reg.ctrl[i][`ACEC_BIT_EN] &&
               sense_hit(s_reg.ctrl[i][`ACEC_SENSE_MSB:`ACEC_SENSE_LSB],
                         s_reg.level[i], cmp_out_raw[i]);
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `ACEC_OFS_CTRL1:    s_next.ctrl[1] = reg_wdata;
        `ACEC_OFS_CTRL2:    s_next.ctrl[2] = reg_wdata & 8'hf7;
        `ACEC_OFS_CTRL3:    s_next.ctrl[3] = reg_wdata & 8'hf7;
        `ACEC_OFS_STATUS:   w1c = reg_wdata[7:`ACEC_FLAG_LSB];
        `ACEC_OFS_IRQ_MASK: s_next.irq_mask = reg_wdata[3:0];
        default:            s_next.irq_mask = s_reg.irq_mask;
      endcase
    end

    // Flags: a new event wins over any clear in the same cycle
    s_next.flag = (s_reg.flag & ~(w1c | ack_clr)) | evt;

    // Sticky interrupt status, cleared by reading it
    s_next.irq_stat = s_reg.irq_stat;
    if (reg_rd && reg_addr == `ACEC_OFS_IRQ_STAT) begin
      s_next.irq_stat = 4'h0;
    end
    s_next.irq_stat = s_next.irq_stat | evt;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    // Per-comparator requests follow flag and enable
    s_next.cmp_irq = s_next.flag & {s_next.ctrl[3][`ACEC_BIT_IE],
                                    s_next.ctrl[2][`ACEC_BIT_IE],
                                    s_next.ctrl[1][`ACEC_BIT_IE],
                                    cmp0_irq_en};

    // Live comparator levels
    s_next.level = {cmp_out_raw, cmp0_out};

    // Capture path exists only while routing is set
    s_next.cap_level = route & cmp_out_raw[1];
    s_next.cap_event = route && (timer_capture_edge_sel ?
                       (~s_reg.level[1] & cmp_out_raw[1]) :
                       (s_reg.level[1] & ~cmp_out_raw[1]));

    // Read data for the cycle after the strobe
    s_next.rdata = reg_rd ? rd_val : 8'h00;
  end

  // State register, all reset values are zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs, straight from the state register
  assign reg_rdata     = s_reg.rdata;
  assign cmp_irq_req   = s_reg.cmp_irq;
  assign irq           = s_reg.irq;
  assign cmp_trigger   = s_reg.flag;
  assign capture_src   = s_reg.cap_level;
  assign capture_event = s_reg.cap_event;

  // Per-comparator analog controls
  genvar g;
  generate
    for (g = 1; g < 4; g++) begin : g_cmp
      assign cmp_enable[g]    = s_reg.ctrl[g][`ACEC_BIT_EN];
      assign cmp_neg_sel[g]   = s_reg.ctrl[g][`ACEC_NEG_MSB:`ACEC_NEG_LSB];
      assign cmp_neg_valid[g] = s_reg.ctrl[g][`ACEC_NEG_MSB:`ACEC_NEG_LSB]
                                != `ACEC_NEG_RSVD;
    end
  endgenerate

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic st_wr;
  assign st_wr = reg_wr && reg_addr == `ACEC_OFS_STATUS;

  generate
    for (g = 1; g < 4; g++) begin : g_chk
      chk_toggle_sets: assert property (
        s_reg.ctrl[g][7] && s_reg.ctrl[g][5:4] == 2'h0 &&
        cmp_out_raw[g] != s_reg.level[g] |=> cmp_trigger[g])
        else $error("toggle event did not set flag");

      chk_rise_sets: assert property (
        s_reg.ctrl[g][7] && s_reg.ctrl[g][5:4] == 2'h3 &&
        !s_reg.level[g] && cmp_out_raw[g] |=> cmp_trigger[g] ##1 1'b1)
        else $error("rising event did not set flag");

      chk_fall_only: assert property (
        s_reg.ctrl[g][7] && s_reg.ctrl[g][5:4] == 2'h2 &&
        !s_reg.level[g] && cmp_out_raw[g] && !cmp_trigger[g] && !st_wr
        |=> !cmp_trigger[g])
        else $error("rising edge set a falling-edge flag");

      chk_quiet_holds: assert property (
        (!s_reg.ctrl[g][7] || s_reg.ctrl[g][5:4] == 2'h1) &&
        !st_wr && !vector_ack[g]
        |=> cmp_trigger[g] == $past(cmp_trigger[g]))
        else $error("disabled comparator changed its flag");

      chk_w1c_clears: assert property (
        st_wr && reg_wdata[4 + g] && !evt[g] |=> !cmp_trigger[g])
        else $error("write one did not clear flag");

      chk_ack_clears: assert property (
        vector_ack[g] && s_reg.ctrl[g][6] && !evt[g] |=> !cmp_trigger[g])
        else $error("vector did not clear flag");

      chk_req_follows: assert property (
        cmp_irq_req[g] == (cmp_trigger[g] && s_reg.ctrl[g][6]))
        else $error("interrupt request disagrees with flag");

      chk_neg_valid: assert property (
        $changed(cmp_neg_sel[g]) |-> cmp_neg_valid[g] == (cmp_neg_sel[g] != 3'h7))
        else $error("negative select validity wrong");

      // Edge choice, register fields, enables and clearing, per comparator
      chk_fall_sets: assert property (
        s_reg.ctrl[g][7] && s_reg.ctrl[g][5:4] == 2'h2 &&
        s_reg.level[g] && !cmp_out_raw[g] |=> cmp_trigger[g])
        else $error("falling event did not set flag");

      chk_rise_only: assert property (
        s_reg.ctrl[g][7] && s_reg.ctrl[g][5:4] == 2'h3 &&
        s_reg.level[g] && !cmp_out_raw[g] && !cmp_trigger[g] && !st_wr
        |=> !cmp_trigger[g])
        else $error("falling edge set a rising-edge flag");

      chk_ctrl_enable: assert property (
        reg_wr && reg_addr == 4'(g - 1) |=> cmp_enable[g] == $past(reg_wdata[7]))
        else $error("enable bit not taken from write");

      chk_neg_code: assert property (
        reg_wr && reg_addr == 4'(g - 1) |=> cmp_neg_sel[g] == $past(reg_wdata[2:0]))
        else $error("negative select not taken from write");

      chk_ie_masks: assert property (
        !s_reg.ctrl[g][6] && !reg_wr |=> !cmp_irq_req[g])
        else $error("request raised with interrupt disabled");

      chk_level_live: assert property (
        1'b1 |=> s_reg.level[g] == $past(cmp_out_raw[g]))
        else $error("sampled level does not follow comparator");

      chk_w1c_keeps: assert property (
        st_wr && !reg_wdata[4 + g] && !vector_ack[g] && cmp_trigger[g]
        |=> cmp_trigger[g])
        else $error("write zero cleared flag");

      chk_ack_needs_ie: assert property (
        vector_ack[g] && !s_reg.ctrl[g][6] && cmp_trigger[g] && !st_wr
        |=> cmp_trigger[g])
        else $error("vector cleared flag with interrupt disabled");
    end
  endgenerate

  chk_event_wins: assert property (
    st_wr && (reg_wdata[7:4] & evt) != 4'h0 |=> (cmp_trigger & $past(evt)) == $past(evt))
    else $error("event lost during clear");

  chk_no_route: assert property (
    !s_reg.ctrl[1][3] |=> !capture_src && !capture_event)
    else $error("capture path active without routing");

  chk_capture_rise: assert property (
    s_reg.ctrl[1][3] && timer_capture_edge_sel && !s_reg.level[1] && cmp_out_raw[1]
    |=> capture_event ##1 !capture_event || $past(cmp_out_raw[1]) != cmp_out_raw[1])
    else $error("rising capture edge missed");

  chk_capture_fall: assert property (
    s_reg.ctrl[1][3] && !timer_capture_edge_sel && s_reg.level[1] && !cmp_out_raw[1]
    |=> capture_event && !capture_src)
    else $error("falling capture edge missed");

  chk_rsvd_zero: assert property (
    reg_rd && (reg_addr == 4'h1 || reg_addr == 4'h2) |=> !reg_rdata[3])
    else $error("reserved control bit read as one");

  chk_status_live: assert property (
    reg_rd && reg_addr == 4'h3 |=> reg_rdata[3:1] == $past(s_reg.level[3:1]))
    else $error("status read does not show outputs");

  chk_rdata_once: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  chk_irq_level: assert property (
    irq == |(s_reg.irq_stat & s_reg.irq_mask))
    else $error("summary interrupt wrong");

  // Status read, capture edge and sticky interrupt status
  chk_status_flags: assert property (
    reg_rd && reg_addr == 4'h3 |=> reg_rdata[7:4] == $past(cmp_trigger))
    else $error("status read does not show flags");

  chk_route_level: assert property (
    s_reg.ctrl[1][3] |=> capture_src == $past(cmp_out_raw[1]))
    else $error("routed level not passed to capture");

  chk_capture_quiet: assert property (
    s_reg.ctrl[1][3] && timer_capture_edge_sel && s_reg.level[1] && !cmp_out_raw[1]
    |=> !capture_event)
    else $error("falling edge captured with rising selected");

  chk_capture_single: assert property (
    capture_event && $stable(timer_capture_edge_sel) |=> !capture_event)
    else $error("capture event longer than one cycle");

  chk_cmp0_sets: assert property (
    cmp0_event |=> cmp_trigger[0])
    else $error("comparator 0 event did not set flag");

  chk_stat_sticky: assert property (
    evt != 4'h0 |=> (s_reg.irq_stat & $past(evt)) == $past(evt))
    else $error("event did not set sticky status");

  chk_stat_rdclr: assert property (
    reg_rd && reg_addr == 4'h4 && evt == 4'h0 |=> s_reg.irq_stat == 4'h0)
    else $error("status read did not clear sticky bits");

  chk_stat_read: assert property (
    reg_rd && reg_addr == 4'h4 |=> reg_rdata == {4'h0, $past(s_reg.irq_stat)})
    else $error("sticky status read data wrong");

  chk_mask_taken: assert property (
    reg_wr && reg_addr == 4'h5 |=> s_reg.irq_mask == $past(reg_wdata[3:0]))
    else $error("mask not taken from write");

endmodule // acec_ctrl

// >>> verif/acec_partner.sv
`timescale 1ns/100ps

module acec_partner (
  // Clock and reset
  input  logic       sys_clk,
  input  logic       reset,
  // Interrupt controller side
  input  logic [3:0] cmp_irq_req,
  input  logic       ack_on,
  output logic [3:0] vector_ack,
  // Timer capture side
  input  logic       capture_event,
  input  logic       timer_capture_irq_en,
  output logic [7:0] capture_count
);
  // Takes the lowest pending vector as a single pulse, then lets the request drop
  always_ff @(posedge sys_clk) begin
    if (reset || !ack_on || vector_ack != 4'h0) begin
      vector_ack <= 4'h0;
    end else begin
      vector_ack <= cmp_irq_req & (~cmp_irq_req + 4'h1);
    end
  end
  // Capture interrupts are counted only while the timer enable is set
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      capture_count <= 8'h00;
    end else if (capture_event && timer_capture_irq_en) begin
      capture_count <= capture_count + 8'h01;
    end
  end
endmodule // acec_partner

// >>> verif/analog_comparator_event_ctrl_bench.sv
`timescale 1ns/100ps
`include "acec_regs.svh"
`define BENCH_CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module analog_comparator_event_ctrl_bench;
  // Stimulus and observed signals
  logic            sys_clk = 1'b0;
  logic            reset = 1'b1;
  logic [3:0]      reg_addr = 4'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [3:1]      cmp_out_raw = 3'h0;
  logic            cmp0_out = 1'b0;
  logic            cmp0_event = 1'b0;
  logic            cmp0_irq_en = 1'b0;
  logic            edge_sel = 1'b0;
  logic            ack_on = 1'b0;
  logic [7:0]      reg_rdata, cap_count;
  logic [3:1]      cmp_enable, cmp_neg_valid;
  logic [3:1][2:0] cmp_neg_sel;
  logic [3:0]      vector_ack, cmp_irq_req, cmp_trigger;
  logic            irq, capture_src, capture_event;
  int              n_mismatch = 0;
  int              num_checks = 0;

  always #5 sys_clk = ~sys_clk;

  acec_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_out_raw(cmp_out_raw), .cmp_enable(cmp_enable), .cmp_neg_sel(cmp_neg_sel),
    .cmp_neg_valid(cmp_neg_valid), .cmp0_out(cmp0_out), .cmp0_event(cmp0_event),
    .cmp0_irq_en(cmp0_irq_en), .vector_ack(vector_ack), .cmp_irq_req(cmp_irq_req), .irq(irq),
    .cmp_trigger(cmp_trigger), .timer_capture_edge_sel(edge_sel),
    .capture_src(capture_src), .capture_event(capture_event));

  acec_partner i_partner (.sys_clk(sys_clk), .reset(reset), .cmp_irq_req(cmp_irq_req),
    .ack_on(ack_on), .vector_ack(vector_ack), .capture_event(capture_event),
    .timer_capture_irq_en(1'b1), .capture_count(cap_count));

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `BENCH_CHK(reg_rdata, e)
  endtask
  // Moves one comparator output and lets the event settle
  task automatic raw(input int i, input logic v);
    @(posedge sys_clk);
    cmp_out_raw[i] <= v;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Reset values and an unmapped address
  task automatic t_reset();
    rd(`ACEC_OFS_CTRL2, `ACEC_CTRL_RST);
    rd(`ACEC_OFS_STATUS, `ACEC_STATUS_RST);
    rd(4'hf, 8'h00);
  endtask

  // Field layout, unused bit and select decode
  task automatic t_fields();
    wr(`ACEC_OFS_CTRL1, 8'hff);
    wr(`ACEC_OFS_CTRL2, 8'hff);
    wr(`ACEC_OFS_CTRL3, 8'h7d);
    rd(`ACEC_OFS_CTRL1, 8'hff);
    rd(`ACEC_OFS_CTRL2, 8'hf7);
    rd(`ACEC_OFS_CTRL3, 8'h75);
    `BENCH_CHK(cmp_enable, 3'b011)
    `BENCH_CHK(cmp_neg_sel, 9'h17f)
    `BENCH_CHK(cmp_neg_valid, 3'b100)
  endtask

  // Every sensitivity code on both edges of comparator 2
  task automatic t_sense();
    logic [1:0] s;
    for (int c = 0; c < 4; c++) begin
      s = c[1:0];
      wr(`ACEC_OFS_CTRL2, {2'b10, s, 4'h0});
      raw(2, 1'b1);
      `BENCH_CHK(cmp_trigger[2], s == 2'h0 || s == 2'h3)
      wr(`ACEC_OFS_STATUS, 8'h40);
      raw(2, 1'b0);
      `BENCH_CHK(cmp_trigger[2], s == 2'h0 || s == 2'h2)
      wr(`ACEC_OFS_STATUS, 8'h40);
    end
    raw(2, 1'b1);
    wr(`ACEC_OFS_STATUS, 8'h00);
    rd(`ACEC_OFS_STATUS, 8'h44);
    `BENCH_CHK(cmp_irq_req[2], 1'b0)
    wr(`ACEC_OFS_STATUS, 8'h40);
    wr(`ACEC_OFS_CTRL2, 8'h00);
    raw(2, 1'b0);
    `BENCH_CHK(cmp_trigger[2], 1'b0)
  endtask

  // Interrupt request, sticky status, mask and vector clear
  task automatic t_irq();
    int k;
    wr(`ACEC_OFS_IRQ_MASK, 8'h08);
    wr(`ACEC_OFS_CTRL3, 8'hc0);
    raw(3, 1'b1);
    `BENCH_CHK({cmp_irq_req[3], irq}, 2'b11)
    rd(`ACEC_OFS_IRQ_STAT, 8'h0c);
    rd(`ACEC_OFS_IRQ_STAT, 8'h00);
    `BENCH_CHK(irq, 1'b0)
    @(posedge sys_clk);
    ack_on <= 1'b1;
    for (k = 0; k < 10 && cmp_trigger[3] !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    `BENCH_CHK(cmp_trigger[3], 1'b0)
    if (k == 10) finish_test();
    @(posedge sys_clk);
    cmp0_event <= 1'b1;
    cmp0_out <= 1'b1;
    @(posedge sys_clk);
    cmp0_event <= 1'b0;
    rd(`ACEC_OFS_STATUS, 8'h19);
    `BENCH_CHK({cmp_trigger, irq}, 5'h02)
    // Comparator 0 flag taken by its vector once its enable is set
    @(posedge sys_clk);
    cmp0_irq_en <= 1'b1;
    for (k = 0; k < 10 && cmp_trigger[0] !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    `BENCH_CHK(cmp_trigger[0], 1'b0)
    if (k == 10) finish_test();
  endtask

  // Capture routing on both edge selections, then routing off
  task automatic t_capture();
    wr(`ACEC_OFS_CTRL1, 8'h08);
    edge_sel <= 1'b1;
    raw(1, 1'b1);
    `BENCH_CHK({capture_src, cap_count}, {1'b1, 8'h01})
    raw(1, 1'b0);
    `BENCH_CHK(cap_count, 8'h01)
    edge_sel <= 1'b0;
    raw(1, 1'b1);
    raw(1, 1'b0);
    `BENCH_CHK(cap_count, 8'h02)
    wr(`ACEC_OFS_CTRL1, 8'h00);
    raw(1, 1'b1);
    `BENCH_CHK({capture_src, cap_count}, {1'b0, 8'h02})
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_sense();
    t_irq();
    t_capture();
    finish_test();
  end
endmodule // analog_comparator_event_ctrl_bench
